// [src/cic_core_cfg.sv]
// core implementation configuration: window pointer, ancillary
// registers, fp status and trap decisions behind an APB slave
// assumes an APB master on clk_in and software as the only party
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_core_cfg #(
  parameter logic [15:0] IMPL_CODE  = 16'h00A5, // arbitrary value
  parameter logic [2:0]  FPU_VER    = 3'h5      // arbitrary value
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire cic_pkg::cic_apb_req_t apb_req_in,
  output cic_pkg::cic_apb_rsp_t     apb_rsp_out,
  output logic                      irq_out,
  output logic [2:0]                trap_code_out
);

  cic_pkg::cic_state_t s_reg;
  cic_pkg::cic_state_t s_next;

  logic        wr_acc;
  logic        rd_setup;
  logic        acc;
  logic        mapped;
  logic [31:0] wd;
  logic [7:0]  addr;
  logic [31:0] rd_mux;
  logic [31:0] fsr_view;
  logic [31:0] ver_view;
  logic [3:0]  cmd_op;
  logic        cmd_priv;
  logic [4:0]  cmd_sel;
  logic [1:0]  cmd_gset;
  logic        cmd_ext;
  logic [7:0]  phys_idx;
  logic        is_denorm;
  logic [4:0]  raised;
  logic [5:0]  evt_set;
  logic [5:0]  evt_clr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign addr     = apb_req_in.paddr;
  assign wd       = apb_req_in.pwdata;
  assign acc      = apb_req_in.psel & apb_req_in.penable;
  assign wr_acc   = acc & apb_req_in.pwrite & mapped;
  assign rd_setup = apb_req_in.psel & ~apb_req_in.penable & ~apb_req_in.pwrite;

  // command word fields
  assign cmd_op   = wd[`CIC_CMD_OP_LSB +: 4];
  assign cmd_priv = wd[`CIC_CMD_PRIV_BIT];
  assign cmd_sel  = wd[`CIC_CMD_SEL_LSB +: 5];
  assign cmd_gset = wd[`CIC_CMD_GSET_LSB +: 2];
  assign cmd_ext  = wd[`CIC_CMD_EXT_BIT];

  // address decode, unmapped words answer with an error
  always_comb
  begin
    case (addr)
      `CIC_OFF_CMD,
      `CIC_OFF_OPERAND,
      `CIC_OFF_RESULT,
      `CIC_OFF_TRAP,
      `CIC_OFF_WINDOW,
      `CIC_OFF_FSR,
      `CIC_OFF_VERSION,
      `CIC_OFF_EXT_ARITH,
      `CIC_OFF_INT_STATUS,
      `CIC_OFF_INT_MASK: mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  // fp status view and fixed version fields
  always_comb
  begin
    fsr_view = `CIC_RST_ZERO;
    fsr_view[`CIC_FSR_CEXC_LSB +: 5] = s_reg.cexc;
    fsr_view[`CIC_FSR_AEXC_LSB +: 5] = s_reg.aexc;
    fsr_view[`CIC_FPU_VERSION_FIELD_LSB +: 3]  = FPU_VER;
    fsr_view[`CIC_FP_NONSTANDARD_MODE_BIT_BIT]        = s_reg.ns;
    fsr_view[`CIC_FSR_MASK_LSB +: 5] = s_reg.fp_trap_enable_mask;
    ver_view = `CIC_RST_ZERO;
    ver_view[`CIC_VER_IMPL_LSB +: 16] = IMPL_CODE;
    ver_view[4:0] = 5'(`REGISTER_WINDOW_COUNT - 1);
  end

  // read data selection
  always_comb
  begin
    case (addr)
      `CIC_OFF_OPERAND:    rd_mux = s_reg.operand;
      `CIC_OFF_RESULT:     rd_mux = s_reg.result;
      `CIC_OFF_TRAP:       rd_mux = {29'h0000_0000, s_reg.trap};
      `CIC_OFF_WINDOW:     rd_mux = {29'h0000_0000, s_reg.cwp};
      `CIC_OFF_FSR:        rd_mux = fsr_view;
      `CIC_OFF_VERSION:    rd_mux = ver_view;
      `CIC_OFF_EXT_ARITH:  rd_mux = s_reg.ext_arith;
      `CIC_OFF_INT_STATUS: rd_mux = {26'h000_0000, s_reg.int_status};
      `CIC_OFF_INT_MASK:   rd_mux = {26'h000_0000, s_reg.int_mask};
      default:             rd_mux = `CIC_RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // register mapping helper
  // ----------------------------------------------------------------
  cic_reg_map u_map (
    .cwp_in       (s_reg.cwp),
    .reg_num_in   (cmd_sel),
    .gset_in      (cmd_gset),
    .ext_in       (cmd_ext),
    .phys_idx_out (phys_idx)
  );

  // single-precision denormal: zero exponent, nonzero fraction
  assign is_denorm = (s_reg.operand[30:23] == 8'h00) & (s_reg.operand[22:0] != 23'h00_0000);
  assign raised    = cmd_sel;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next  = s_reg;
    evt_set = 6'h00;
    evt_clr = 6'h00;
    if (rd_setup)
      s_next.prdata = rd_mux;
    if (wr_acc)
    begin
      case (addr)
        `CIC_OFF_OPERAND:   s_next.operand = wd;
        `CIC_OFF_WINDOW:    s_next.cwp = wd[2:0];
        `CIC_OFF_EXT_ARITH: s_next.ext_arith = wd;
        `CIC_OFF_FSR:
        begin
          s_next.cexc = wd[`CIC_FSR_CEXC_LSB +: 5];
          s_next.aexc = wd[`CIC_FSR_AEXC_LSB +: 5];
          s_next.ns   = wd[`CIC_FP_NONSTANDARD_MODE_BIT_BIT];
          s_next.fp_trap_enable_mask = wd[`CIC_FSR_MASK_LSB +: 5];
        end
        `CIC_OFF_INT_STATUS: evt_clr = wd[5:0];
        `CIC_OFF_INT_MASK:   s_next.int_mask = wd[5:0];
        `CIC_OFF_CMD:
        begin
          s_next.trap = cic_pkg::CIC_TRAP_NONE;
          evt_set[5]  = 1'b1;
          case (cmd_op)
            cic_pkg::CIC_OP_RD_ASR:
            begin
              if (cmd_sel == `CIC_ASR_EXT_ARITH)
                s_next.result = s_reg.ext_arith;
              else if (cmd_sel == `CIC_ASR_EXT_STATUS)
                s_next.result = s_reg.ext_status;
              else if (cmd_sel == `CIC_ASR_TRAP_COPY)
              begin
                if (cmd_priv)
                  s_next.result = s_reg.trap_ext_arith;
                else
                  s_next.trap = cic_pkg::CIC_TRAP_PRIV;
              end
              else
                s_next.trap = cic_pkg::CIC_TRAP_ILLEGAL;
            end
            cic_pkg::CIC_OP_WR_ASR:
            begin
              if (cmd_sel == `CIC_ASR_EXT_STATUS)
                s_next.ext_status = s_reg.operand;
              else if (cmd_sel == `CIC_ASR_TRAP_COPY)
              begin
                if (cmd_priv)
                  s_next.trap_ext_arith = s_reg.operand;
                else
                  s_next.trap = cic_pkg::CIC_TRAP_PRIV;
              end
              else
                s_next.trap = cic_pkg::CIC_TRAP_ILLEGAL;
            end
            cic_pkg::CIC_OP_RD_PRIV:
              s_next.trap = cic_pkg::CIC_TRAP_ILLEGAL;
            cic_pkg::CIC_OP_QUAD_FP:
              s_next.trap = s_reg.operand[0] ? cic_pkg::CIC_TRAP_ILLEGAL
                                             : cic_pkg::CIC_TRAP_UNIMPL;
            cic_pkg::CIC_OP_FP_RES:
            begin
              s_next.cexc = raised;
              if ((raised & s_reg.fp_trap_enable_mask) != 5'h00)
                s_next.trap = cic_pkg::CIC_TRAP_FP_IEEE;
              else
              begin
                s_next.aexc = s_reg.aexc | raised;
                if (s_reg.ns && is_denorm)
                begin
                  s_next.result = {s_reg.operand[31], 31'h0000_0000};
                  evt_set[4]    = 1'b1;
                end
                else
                  s_next.result = s_reg.operand;
              end
            end
            cic_pkg::CIC_OP_MAP_REG:
              s_next.result = {24'h00_0000, phys_idx};
            cic_pkg::CIC_OP_SAVE:    s_next.cwp = s_reg.cwp + 3'h1;
            cic_pkg::CIC_OP_RESTORE: s_next.cwp = s_reg.cwp - 3'h1;
            cic_pkg::CIC_OP_NOP:     s_next.trap = cic_pkg::CIC_TRAP_NONE;
            default:                 s_next.trap = cic_pkg::CIC_TRAP_ILLEGAL;
          endcase
          // trap events
          case (s_next.trap)
            cic_pkg::CIC_TRAP_PRIV:    evt_set[0] = 1'b1;
            cic_pkg::CIC_TRAP_ILLEGAL: evt_set[1] = 1'b1;
            cic_pkg::CIC_TRAP_UNIMPL:  evt_set[2] = 1'b1;
            cic_pkg::CIC_TRAP_FP_IEEE: evt_set[3] = 1'b1;
            default:                   evt_set[0] = 1'b0;
          endcase
        end
        default: s_next.prdata = s_reg.prdata;
      endcase
    end
    // sticky status, a new event wins over its clear
    s_next.int_status = (s_reg.int_status & ~evt_clr) | evt_set;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_reg.cwp                 <= 3'h0;
      s_reg.operand             <= `CIC_RST_ZERO;
      s_reg.result              <= `CIC_RST_ZERO;
      s_reg.trap                <= cic_pkg::CIC_TRAP_NONE;
      s_reg.ns                  <= 1'b0;
      s_reg.fp_trap_enable_mask <= 5'h00;
      s_reg.aexc                <= 5'h00;
      s_reg.cexc                <= 5'h00;
      s_reg.ext_arith           <= `CIC_RST_ZERO;
      s_reg.ext_status          <= `CIC_RST_ZERO;
      s_reg.trap_ext_arith      <= `CIC_RST_ZERO;
      s_reg.int_status          <= 6'h00;
      s_reg.int_mask            <= 6'h00;
      s_reg.prdata              <= `CIC_RST_ZERO;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp_out.prdata  = s_reg.prdata;
  assign apb_rsp_out.pready  = 1'b1;             // zero wait states
  assign apb_rsp_out.pslverr = acc & ~mapped;
  assign irq_out             = |(s_reg.int_status & s_reg.int_mask);
  assign trap_code_out       = s_reg.trap;

endmodule : cic_core_cfg

// [src/cic_defs.svh]
// constants of the core implementation configuration block
// assumes APB with 32-bit data and an 8-bit byte address
//
// Notes on behaviour
// - eight register windows, pointer wraps modulo eight
// - three extra global sets, 192 integer registers
// - ancillary read three registers, write two
// - trap copy register only in privileged mode
// - no integer deferred-trap queue, traps immediate
// - nonstandard mode flushes denormal results to zero
// - implementation and fpu version codes read-only
// - all trap mask and exception bits writable
// - fp traps precise, faulting result discarded
// - quad-precision ops trap, unimplemented for software emulation when operand bit 0 is clear, else illegal
// - privileged read of fp queue is illegal
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CIC_OFF_CMD        8'h00
`define CIC_OFF_OPERAND    8'h04
`define CIC_OFF_RESULT     8'h08
`define CIC_OFF_TRAP       8'h0C
`define CIC_OFF_WINDOW     8'h10
`define CIC_OFF_FSR        8'h14
`define CIC_OFF_VERSION    8'h18
`define CIC_OFF_EXT_ARITH  8'h1C
`define CIC_OFF_INT_STATUS 8'h20
`define CIC_OFF_INT_MASK   8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CIC_CMD_OP_LSB     0
`define CIC_CMD_PRIV_BIT   4
`define CIC_CMD_SEL_LSB    5
`define CIC_CMD_GSET_LSB   10
`define CIC_CMD_EXT_BIT    12
`define CIC_FSR_CEXC_LSB   0
`define CIC_FSR_AEXC_LSB   5
`define CIC_FPU_VERSION_FIELD_LSB    17
`define CIC_FP_NONSTANDARD_MODE_BIT_BIT     22
`define CIC_FSR_MASK_LSB   23
`define CIC_VER_IMPL_LSB   16

// ----------------------------------------------------------------
// ancillary register numbers and sizes
// ----------------------------------------------------------------
`define CIC_ASR_EXT_ARITH  5'h1D
`define CIC_ASR_EXT_STATUS 5'h1E
`define CIC_ASR_TRAP_COPY  5'h1F
`define REGISTER_WINDOW_COUNT 8
`define CIC_INT_REG_TOTAL  192
`define CIC_WINDOW_REGS    16
`define CIC_GLOBAL_BASE    8'h80
`define CIC_EXT_BASE       8'hA0
`define CIC_RST_ZERO       32'h0000_0000

`endif

// [src/cic_pkg.sv]
// types of the core implementation configuration block
// op and trap codes set here, other numeric constants in cic_defs.svh
package cic_pkg;

  // ----------------------------------------------------------------
  // command and trap codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CIC_OP_NOP      = 4'h0,
    CIC_OP_RD_ASR   = 4'h1,
    CIC_OP_WR_ASR   = 4'h2,
    CIC_OP_RD_PRIV  = 4'h3,
    CIC_OP_QUAD_FP  = 4'h4,
    CIC_OP_FP_RES   = 4'h5,
    CIC_OP_MAP_REG  = 4'h6,
    CIC_OP_SAVE     = 4'h7,
    CIC_OP_RESTORE  = 4'h8
  } cic_op_t;

  typedef enum logic [2:0] {
    CIC_TRAP_NONE    = 3'h0,
    CIC_TRAP_PRIV    = 3'h1,
    CIC_TRAP_ILLEGAL = 3'h2,
    CIC_TRAP_UNIMPL  = 3'h3,
    CIC_TRAP_FP_IEEE = 3'h4
  } cic_trap_t;

  // ----------------------------------------------------------------
  // bus carriers and module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cic_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cic_apb_rsp_t;

  typedef struct packed {
    logic [2:0]  cwp;
    logic [31:0] operand;
    logic [31:0] result;
    cic_trap_t   trap;
    logic        ns;
    logic [4:0]  fp_trap_enable_mask;
    logic [4:0]  aexc;
    logic [4:0]  cexc;
    logic [31:0] ext_arith;
    logic [31:0] ext_status;
    logic [31:0] trap_ext_arith;
    logic [5:0]  int_status;
    logic [5:0]  int_mask;
    logic [31:0] prdata;
  } cic_state_t;

endpackage : cic_pkg

// [src/cic_reg_map.sv]
// maps an architectural integer register to its physical index
// assumes a window pointer already wrapped to three bits
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_reg_map (
  input  wire logic [2:0] cwp_in,
  input  wire logic [4:0] reg_num_in,
  input  wire logic [1:0] gset_in,
  input  wire logic       ext_in,
  output logic      [7:0] phys_idx_out
);

  logic [2:0] next_win;
  logic [7:0] win_base;
  logic [7:0] next_base;

  // ----------------------------------------------------------------
  // window bases, outs of one window are ins of the next
  // ----------------------------------------------------------------
  // wrap window index
  assign next_win  = cwp_in + 3'h1;
  assign win_base  = {1'b0, cwp_in, 4'h0};
  assign next_base = {1'b0, next_win, 4'h0};

  always_comb
  begin
    if (ext_in)
      phys_idx_out = `CIC_EXT_BASE + {3'h0, reg_num_in};
    else if (reg_num_in[4:3] == 2'h0)
      phys_idx_out = `CIC_GLOBAL_BASE + {3'h0, gset_in, reg_num_in[2:0]};
    else if (reg_num_in[4:3] == 2'h1)
      phys_idx_out = next_base + {5'h01, reg_num_in[2:0]}; // outs
    else if (reg_num_in[4:3] == 2'h2)
      phys_idx_out = win_base + {5'h00, reg_num_in[2:0]};  // locals
    else
      phys_idx_out = win_base + {5'h01, reg_num_in[2:0]};  // ins
  end

endmodule : cic_reg_map

// [verification/cic_core_cfg_chk.sv]
// checker for the core configuration block, bound to its ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cic_core_cfg_chk #(
  parameter logic [15:0] IMPL_CODE = 16'h00A5, // arbitrary value
  parameter logic [2:0]  FPU_VER   = 3'h5      // arbitrary value
) (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire cic_pkg::cic_apb_req_t apb_req_in,
  input wire cic_pkg::cic_apb_rsp_t apb_rsp_out,
  input wire logic                  irq_out,
  input wire logic [2:0]            trap_code_out
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic       wr_cmd;
  logic       rd_acc;
  logic [9:0] cw;
  // command write, read access and low command word bits
  assign wr_cmd = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & (apb_req_in.paddr == 8'h00);
  assign rd_acc = apb_req_in.psel & apb_req_in.penable & ~apb_req_in.pwrite;
  assign cw     = apb_req_in.pwdata[9:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // queue read illegal
  property p_fpq; wr_cmd && cw[3:0] == 4'h3 |=> trap_code_out == 3'h2; endproperty
  a_fpq: assert property (p_fpq) else $error("fp queue read not illegal");
  property p_quad; wr_cmd && cw[3:0] == 4'h4 |=> trap_code_out inside {3'h2, 3'h3}; endproperty
  a_quad: assert property (p_quad) else $error("quad op did not trap");
  property p_priv; wr_cmd && cw[9:4] == 6'h3E && cw[3:0] inside {4'h1, 4'h2} |=> trap_code_out == 3'h1; endproperty
  a_priv: assert property (p_priv) else $error("trap copy open to user");
  property p_wxar; wr_cmd && cw[9:5] == 5'h1D && cw[3:0] == 4'h2 |=> trap_code_out == 3'h2; endproperty
  a_wxar: assert property (p_wxar) else $error("ext arith write accepted");
  property p_rasr; wr_cmd && cw[9:5] inside {5'h1D, 5'h1E} && cw[3:0] == 4'h1 |=> trap_code_out == 3'h0; endproperty
  a_rasr: assert property (p_rasr) else $error("ancillary read refused");
  property p_win; wr_cmd && cw[3:0] inside {4'h7, 4'h8} |=> trap_code_out == 3'h0; endproperty
  a_win: assert property (p_win) else $error("window op trapped");
  property p_ver; rd_acc && apb_req_in.paddr == 8'h18 |-> apb_rsp_out.prdata[31:16] == IMPL_CODE
    && apb_rsp_out.prdata[4:0] == 5'h07; endproperty
  a_ver: assert property (p_ver) else $error("version word wrong");
  property p_fver; rd_acc && apb_req_in.paddr == 8'h14 |-> apb_rsp_out.prdata[19:17] == FPU_VER; endproperty
  a_fver: assert property (p_fver) else $error("fpu version wrong");
  // interrupt level follows a cleared mask
  property p_irq_off; apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_req_in.paddr == 8'h24
    && apb_req_in.pwdata[5:0] == 6'h00 |=> !irq_out; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high with mask cleared"); // interrupt mask
  // error response only in an access phase
  property p_err_acc; !(apb_req_in.psel && apb_req_in.penable) |-> !apb_rsp_out.pslverr; endproperty
  a_err_acc: assert property (p_err_acc) else $error("slave error outside access"); // bus response
endmodule : cic_core_cfg_chk

bind cic_core_cfg cic_core_cfg_chk #(.IMPL_CODE(IMPL_CODE), .FPU_VER(FPU_VER)) chk_u (.clk_in(clk_in),
  .rst_in(rst_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .irq_out(irq_out),
  .trap_code_out(trap_code_out));

// [verification/cpu_impl_config_tb_top.sv]
// self-checking bench for the core configuration block
// assumes cic_pkg, the design and the checker compiled first
`timescale 1ns/1ps
module cpu_impl_config_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL = 16'h3C5A; // arbitrary value
  localparam logic [2:0]  FVER = 3'h3;     // arbitrary value
  logic                  clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  cic_pkg::cic_apb_req_t req    = '0;
  cic_pkg::cic_apb_rsp_t rsp;
  logic                  irq;
  logic [2:0]            trap;
  logic [31:0]           q;
  logic                  e;
  logic [2:0]            w;
  logic [31:0]           d;
  int                    err_count = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;

  cic_core_cfg #(.IMPL_CODE(IMPL), .FPU_VER(FVER)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .irq_out(irq), .trap_code_out(trap));

  // clock and hang limit
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, access until pready
  // no local limit: a slave that never answers is caught by the cycle ceiling
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: v};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    chk(q, v, "read data");
  endtask : rd

  // command word: ext, gset, sel, priv, op
  task automatic cmd(input logic [12:0] cw, input logic [2:0] xt);
    apb(1'b1, 8'h00, {19'h0, cw});
    rd(8'h0C, {29'h0, xt});
    chk({29'h0, trap}, {29'h0, xt}, "trap port");
  endtask : cmd

  task automatic irq_is(input logic v);
    @(negedge clk_in);
    chk({31'h0, irq}, {31'h0, v}, "irq level");
  endtask : irq_is

  // physical index of an architectural register
  function automatic logic [31:0] map_exp(input logic [2:0] c, input logic [4:0] n, input logic [1:0] s,
                                          input logic xe);
    logic [31:0] nw;
    nw = {27'h0, n};
    if (xe) return 32'hA0 + nw;
    if (n < 5'h08) return 32'h80 + {27'h0, s, 3'h0} + nw;
    if (n < 5'h10) return {25'h0, c + 3'h1, 4'h0} + nw;
    return {25'h0, c, 4'h0} + nw - 32'h10;
  endfunction : map_exp

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hE8738005));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    apb(1'b0, 8'h18, 32'h0);
    chk({11'h0, q[31:16], q[4:0]}, {11'h0, IMPL, 5'h07}, "version");
    repeat (4)
    begin
      d = $urandom();
      apb(1'b1, 8'h14, d);
      rd(8'h14, (d & 32'h0FC003FF) | {12'h0, FVER, 17'h0});
    end
    // window moves and register mapping
    w = 3'($urandom());
    apb(1'b1, 8'h10, {29'h0, w});
    repeat (16)
    begin
      d = $urandom();
      cmd({9'h0, d[0] ? 4'h7 : 4'h8}, 3'h0);
      w = d[0] ? w + 3'h1 : w - 3'h1;
      rd(8'h10, {29'h0, w});
      cmd({d[12:5], 1'b0, 4'h6}, 3'h0);
      rd(8'h08, map_exp(w, d[9:5], d[11:10], d[12]));
    end
    // ancillary registers and privilege
    d = $urandom();
    apb(1'b1, 8'h1C, d);
    apb(1'b1, 8'h04, ~d);
    cmd(13'h3C2, 3'h0);
    cmd(13'h3C1, 3'h0);
    rd(8'h08, ~d);
    cmd(13'h3A1, 3'h0);
    rd(8'h08, d);
    cmd(13'h3B2, 3'h2);
    cmd(13'h3F2, 3'h0);
    apb(1'b1, 8'h04, d);
    cmd(13'h3E2, 3'h1);
    cmd(13'h3E1, 3'h1);
    cmd(13'h3F1, 3'h0);
    rd(8'h08, ~d);
    // illegal queue read with interrupt mask and clear
    apb(1'b1, 8'h20, 32'h3F);
    apb(1'b1, 8'h24, 32'h02);
    cmd(13'h013, 3'h2);
    irq_is(1'b1);
    apb(1'b1, 8'h24, 32'h0);
    irq_is(1'b0);
    apb(1'b1, 8'h24, 32'h02);
    irq_is(1'b1);
    apb(1'b1, 8'h20, 32'h02);
    irq_is(1'b0);
    rd(8'h20, 32'h20);
    cmd(13'h003, 3'h2);
    apb(1'b1, 8'h04, 32'h1);
    cmd(13'h004, 3'h2);
    apb(1'b1, 8'h04, 32'h0);
    cmd(13'h004, 3'h3);
    // denormal flush, precise trap
    apb(1'b1, 8'h20, 32'h3F);
    apb(1'b1, 8'h14, 32'h00C00000);
    apb(1'b1, 8'h04, 32'h80000001);
    cmd(13'h005, 3'h0);
    rd(8'h08, 32'h80000000);
    cmd(13'h025, 3'h4);
    rd(8'h08, 32'h80000000);
    rd(8'h14, 32'h00C00001 | {12'h0, FVER, 17'h0});
    apb(1'b1, 8'h14, 32'h0);
    cmd(13'h005, 3'h0);
    rd(8'h08, 32'h80000001);
    rd(8'h20, 32'h38);
    // unmapped place and nop
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    cmd(13'h000, 3'h0);
    results();
  end
endmodule : cpu_impl_config_tb_top
